// ==== core/lpf_params.svh ====
// Constants for the pixel fetch and palette front end
`ifndef LPF_PARAMS_SVH
`define LPF_PARAMS_SVH
`define LPF_PS_4 2'h0
`define LPF_PS_8 2'h1
`define LPF_PS_WIDE 2'h2
`define LPF_PBS_HI 13
`define LPF_PBS_LO 12
`define LPF_PAL_MOD_4 7'h08
`define LPF_PAL_MOD_8 7'h00
`define LPF_FIFO_DEPTH 5
`define LPF_REQ_LEVEL 3'h1
`define LPF_BEAT_LAST 2'h3
`define LPF_BURST_BYTES 32'h0000_0010
`define LPF_PAL_BYTES_4 32'h0000_0020
`define LPF_PAL_BYTES_8 32'h0000_0200
`define LPF_CNT_W 3
`endif

// ==== core/lpf_pkg.sv ====
// Types shared by the pixel fetch and palette front end
`default_nettype none
package lpf_pkg;
    typedef enum logic [1:0] {
        LPF_IDLE = 2'h1,
        LPF_BURST = 2'h2
    } lpf_fsm_e;

    typedef struct packed {
        lpf_fsm_e fsm;
        logic [1:0][4:0][31:0] fifo;
        logic [1:0][2:0] cnt;
        logic [1:0][31:0] addr;
        logic [1:0] done;
        logic bch;
        logic last_ch;
        logic [1:0] beat;
        logic drop;
        logic req;
        logic [31:0] req_addr;
        logic pal_load;
        logic [6:0] pal_cnt;
        logic [6:0] pal_widx;
        logic first;
        logic [1:0] psize;
        logic [2:0] slot;
        logic pix_valid;
        logic [1:0][15:0] pix;
        logic to_outfifo;
        logic primed;
        logic underrun;
        logic irq;
        logic en_d;
    } lpf_state_s;
endpackage : lpf_pkg
`default_nettype wire

// ==== core/lpf_fetch.sv ====
// Frame buffer fetch, palette load, input FIFOs and pixel unpack
// How it works
// - Code 00: 4-bit pixels, 16-entry palette of 32 bytes; 01: 8-bit, 256 entries.
// - Code 10 bypasses palette but 32 dummy bytes still load; 11 reserved.
// - Two 4-bit pixels per byte; 12-bit pixel is low bits of its half-word.
// - Big-endian order takes most significant pixel first, else least significant.
// - Dual panel uses second channel and FIFO; channels alternate requests.
// - Only channel one loads the palette; channel two starts at pixels.
// - Each channel keeps base and current pointers and computes its end itself.
// - One surplus burst past the end may be read; FIFOs flush on frame pulse.
// - Dual panel splits lines evenly; channel two has no palette part.
// - After enable or frame pulse, first 32 or 512 bytes go to palette.
// - 7-bit counter loads 8 or 0 (wrapping through 128 words), decrements per palette word, ends at zero.
// - Each input FIFO holds five 32-bit words of packed pixels.
// - Four empty entries raise a request answered by a four-word burst.
// - Removing the bottom word shifts remaining entries down one place.
// - Words unpack by pixel size to palette, dither or output paths.
// - Encoded pixel indexes 16 or 256 palette entries.
// - Selected entry goes on: colour holds three 4-bit fields, mono one.
// - Wide modes bypass palette: 12-bit to dither, 16-bit to output FIFO.
// - Pixel size code comes from bits 13:12 of the first palette entry.
// - FIFO emptied while fetching sets sticky underrun and an interrupt request.
`include "lpf_params.svh"
`default_nettype none
module lpf_fetch
    import lpf_pkg::*;
#(
    parameter int DIM_W = 10
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic lcd_enable,
    input wire logic frame_pulse,
    input wire logic dual_panel,
    input wire logic color_mode,
    input wire logic active_display_select,
    input wire logic byte_order_select,
    input wire logic [DIM_W-1:0] pixels_per_line,
    input wire logic [DIM_W-1:0] lines_per_frame,
    input wire logic [31:0] base_addr_ch1,
    input wire logic [31:0] base_addr_ch2,
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic mem_chan,
    input wire logic mem_valid,
    input wire logic [31:0] mem_data,
    output logic pix_valid,
    output logic [15:0] pix_upper,
    output logic [15:0] pix_lower,
    output logic pix_to_outfifo,
    input wire logic pix_ready,
    output logic [1:0] pixel_size_code,
    output logic [31:0] cur_addr_ch1,
    output logic [31:0] cur_addr_ch2,
    output logic underrun,
    output logic underrun_irq,
    input wire logic underrun_clr
);
    // Below four the rounding constant of the line block count no longer fits
    if (DIM_W < 4 || DIM_W > 14) begin : g_chk
        $error("DIM_W out of range");
    end

    lpf_state_s state_ff, nxt_state;
    logic [15:0] pal_mem [256];
    logic pal_we;
    logic [15:0] pal_even, pal_odd;
    logic [1:0] pop, push, want;
    logic restart, take, avail, pick;
    logic [31:0] end_addr [2];
    logic [6:0] cnt_v;
    logic [1:0] psz_new;
    logic [15:0] raw, ent;

    function automatic logic [2:0] lpf_last(input logic [1:0] ps);
        unique case (ps)
            `LPF_PS_8: return 3'h3;
            `LPF_PS_WIDE: return 3'h1;
            default: return 3'h7;
        endcase
    endfunction : lpf_last

    function automatic logic [6:0] lpf_modulus(input logic [1:0] ps);
        return (ps == `LPF_PS_8) ? `LPF_PAL_MOD_8 : `LPF_PAL_MOD_4;
    endfunction : lpf_modulus

    // Pixel at a slot of a word; big-endian walks from the top
    function automatic logic [15:0] lpf_extract(input logic [31:0] w, input logic [1:0] ps,
                                                input logic [2:0] slot, input logic be);
        logic [2:0] pos;
        logic [31:0] sh;
        pos = be ? (lpf_last(ps) - slot) : slot;
        unique case (ps)
            `LPF_PS_8: sh = w >> {pos[1:0], 3'h0};
            `LPF_PS_WIDE: sh = w >> {pos[0], 4'h0};
            default: sh = w >> {pos, 2'h0};
        endcase
        unique case (ps)
            `LPF_PS_8: return {8'h00, sh[7:0]};
            `LPF_PS_WIDE: return sh[15:0];
            default: return {12'h000, sh[3:0]};
        endcase
    endfunction : lpf_extract

    // End pointers: padded line blocks times words per block, halved lines in dual
    logic [DIM_W:0] blocks;
    logic [DIM_W-1:0] lines_ch;
    logic [23:0] pix_words;
    always_comb begin
        blocks = ({1'b0, pixels_per_line} + {{DIM_W-3{1'b0}}, 4'hF}) >> 4;
        lines_ch = dual_panel ? (lines_per_frame >> 1) : lines_per_frame;
        pix_words = 24'((blocks << (lpf_last(state_ff.psize) == 3'h7 ? 1 :
                    lpf_last(state_ff.psize) == 3'h3 ? 2 : 3)) * lines_ch);
        end_addr[0] = base_addr_ch1 + {6'h00, pix_words, 2'h0}
                    + ((state_ff.psize == `LPF_PS_8) ? `LPF_PAL_BYTES_8 : `LPF_PAL_BYTES_4);
        end_addr[1] = base_addr_ch2 + {6'h00, pix_words, 2'h0};
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.en_d = lcd_enable;
        nxt_state.irq = 1'b0;
        nxt_state.req = 1'b0;
        pal_we = 1'b0;
        pal_even = byte_order_select ? mem_data[31:16] : mem_data[15:0];
        pal_odd = byte_order_select ? mem_data[15:0] : mem_data[31:16];
        pop = 2'h0;
        push = 2'h0;
        want = 2'h0;
        pick = 1'b0;
        cnt_v = state_ff.pal_cnt;
        psz_new = state_ff.psize;
        raw = 16'h0000;
        ent = 16'h0000;
        restart = lcd_enable & (~state_ff.en_d | frame_pulse);
        avail = (state_ff.cnt[0] != 3'h0) && (!dual_panel || state_ff.cnt[1] != 3'h0);
        take = avail && !state_ff.pal_load && (!state_ff.pix_valid || pix_ready);
        // Unpack stage, both panels advance together
        if (take) begin
            for (int c = 0; c < 2; c++) begin
                raw = lpf_extract(state_ff.fifo[c][0], state_ff.psize, state_ff.slot,
                                  byte_order_select);
                ent = pal_mem[raw[7:0]];
                if (state_ff.psize == `LPF_PS_WIDE) begin
                    nxt_state.pix[c] = active_display_select ? raw : {4'h0, raw[11:0]};
                end else begin
                    nxt_state.pix[c] = color_mode ? {4'h0, ent[11:0]} : {12'h000, ent[3:0]};
                end
            end
            nxt_state.pix_valid = 1'b1;
            nxt_state.to_outfifo = (state_ff.psize == `LPF_PS_WIDE) && active_display_select;
            if (state_ff.slot == lpf_last(state_ff.psize)) begin
                nxt_state.slot = 3'h0;
                pop = dual_panel ? 2'h3 : 2'h1;
            end else begin
                nxt_state.slot = state_ff.slot + 3'h1;
            end
        end else if (pix_ready) begin
            nxt_state.pix_valid = 1'b0;
        end
        for (int c = 0; c < 2; c++) begin
            if (pop[c]) begin
                for (int i = 0; i < `LPF_FIFO_DEPTH - 1; i++) begin
                    nxt_state.fifo[c][i] = state_ff.fifo[c][i+1];
                end
                nxt_state.cnt[c] = state_ff.cnt[c] - 3'h1;
            end
        end
        // A starving consumer during an unfinished frame is an underrun
        // Channel two never finishes in single panel, so only live channels count
        if (lcd_enable && state_ff.primed && !state_ff.pal_load && !avail
            && !state_ff.pix_valid && pix_ready
            && !(state_ff.done[0] && (state_ff.done[1] || !dual_panel))) begin
            nxt_state.underrun = 1'b1;
            nxt_state.irq = ~state_ff.underrun;
        end else if (underrun_clr) begin
            nxt_state.underrun = 1'b0;
        end
        // Fetch engine
        unique case (state_ff.fsm)
            LPF_IDLE: begin
                nxt_state.drop = 1'b0;
                for (int c = 0; c < 2; c++) begin
                    want[c] = lcd_enable && !state_ff.done[c] && (c == 0 || dual_panel)
                            && (state_ff.cnt[c] <= `LPF_REQ_LEVEL
                                || (c == 0 && state_ff.pal_load));
                end
                pick = want[1] && (!want[0] || !state_ff.last_ch);
                if (want != 2'h0) begin
                    nxt_state.req = 1'b1;
                    nxt_state.req_addr = state_ff.addr[pick];
                    nxt_state.addr[pick] = state_ff.addr[pick] + `LPF_BURST_BYTES;
                    nxt_state.done[pick] = (state_ff.addr[pick] + `LPF_BURST_BYTES)
                                           >= end_addr[pick];
                    nxt_state.bch = pick;
                    nxt_state.last_ch = pick;
                    nxt_state.beat = 2'h0;
                    nxt_state.fsm = LPF_BURST;
                end
            end
            LPF_BURST: begin
                if (mem_valid) begin
                    nxt_state.beat = state_ff.beat + 2'h1;
                    if (state_ff.beat == `LPF_BEAT_LAST) begin
                        nxt_state.fsm = LPF_IDLE;
                    end
                    if (state_ff.drop) begin
                        nxt_state.drop = 1'b1;
                    end else if (!state_ff.bch && state_ff.pal_load) begin
                        pal_we = 1'b1;
                        psz_new = state_ff.first ? pal_even[`LPF_PBS_HI:`LPF_PBS_LO]
                                                 : state_ff.psize;
                        cnt_v = state_ff.first ? lpf_modulus(psz_new) : state_ff.pal_cnt;
                        nxt_state.psize = psz_new;
                        nxt_state.first = 1'b0;
                        nxt_state.pal_cnt = cnt_v - 7'h01;
                        nxt_state.pal_widx = state_ff.pal_widx + 7'h01;
                        nxt_state.pal_load = (cnt_v != 7'h01);
                    end else begin
                        push[state_ff.bch] = 1'b1;
                        nxt_state.fifo[state_ff.bch][nxt_state.cnt[state_ff.bch]] = mem_data;
                        nxt_state.cnt[state_ff.bch] = nxt_state.cnt[state_ff.bch] + 3'h1;
                        nxt_state.primed = 1'b1;
                    end
                end
            end
        endcase
        if (restart) begin
            nxt_state.addr[0] = base_addr_ch1;
            nxt_state.addr[1] = base_addr_ch2;
            nxt_state.done = 2'h0;
            nxt_state.cnt = '0;
            nxt_state.pal_load = 1'b1;
            nxt_state.pal_cnt = lpf_modulus(state_ff.psize);
            nxt_state.pal_widx = 7'h00;
            nxt_state.first = 1'b1;
            nxt_state.slot = 3'h0;
            nxt_state.pix_valid = 1'b0;
            nxt_state.primed = 1'b0;
            // Words of a burst already in flight belong to the old frame
            nxt_state.drop = (nxt_state.fsm == LPF_BURST);
        end
        if (!lcd_enable) begin
            nxt_state.fsm = LPF_IDLE;
            nxt_state.cnt = '0;
            nxt_state.pix_valid = 1'b0;
            nxt_state.pal_load = 1'b0;
            nxt_state.primed = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
            state_ff.fsm <= LPF_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Palette holds no reset; every frame reloads it before use
    always_ff @(posedge core_clk) begin
        if (pal_we) begin
            pal_mem[{state_ff.pal_widx, 1'b0}] <= pal_even;
            pal_mem[{state_ff.pal_widx, 1'b1}] <= pal_odd;
        end
    end

    assign mem_req = state_ff.req;
    assign mem_addr = state_ff.req_addr;
    assign mem_chan = state_ff.bch;
    assign pix_valid = state_ff.pix_valid;
    assign pix_upper = state_ff.pix[0];
    assign pix_lower = state_ff.pix[1];
    assign pix_to_outfifo = state_ff.to_outfifo;
    assign pixel_size_code = state_ff.psize;
    assign cur_addr_ch1 = state_ff.addr[0];
    assign cur_addr_ch2 = state_ff.addr[1];
    assign underrun = state_ff.underrun;
    assign underrun_irq = state_ff.irq;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_RESTART_PAL: assert property (restart |=> state_ff.pal_load && state_ff.first)
        else $error("palette load not restarted");
    AST_FLUSH: assert property (restart |=> state_ff.cnt == '0)
        else $error("FIFO not flushed on frame");
    AST_DEPTH: assert property (state_ff.cnt[0] <= 3'h5 && state_ff.cnt[1] <= 3'h5)
        else $error("FIFO count beyond five");
    AST_REQ_ROOM: assert property (mem_req && mem_chan |-> $past(state_ff.cnt[1]) <= 3'h1)
        else $error("request without four free entries");
    AST_BURST4: assert property (mem_req ##1 (!mem_valid && !restart)[*4] |->
                                 state_ff.fsm == LPF_BURST)
        else $error("burst ended early");
    AST_CH2_NOPAL: assert property (pal_we |-> !state_ff.bch)
        else $error("channel two wrote palette");
    AST_PAL_END: assert property (pal_we && !state_ff.first && state_ff.pal_cnt == 7'h01
                                  && !restart |=> !state_ff.pal_load)
        else $error("palette routing did not end");
    AST_PBS: assert property (pal_we && state_ff.first && !restart |=>
                              state_ff.psize == $past(pal_even[13:12]))
        else $error("pixel size not taken from entry 0");
    AST_SHIFT: assert property (pop[0] && !push[0] && !restart && lcd_enable |=>
                                state_ff.fifo[0][0] == $past(state_ff.fifo[0][1]))
        else $error("FIFO did not shift down");
    AST_UR_HOLD: assert property (underrun && !underrun_clr |=> underrun)
        else $error("underrun flag lost");
    COV_RESTART: cover property (restart ##[1:40] !state_ff.pal_load);
    COV_UNDERRUN: cover property ($rose(underrun));
    COV_DUAL: cover property (mem_req && !mem_chan ##[1:20] mem_req && mem_chan);
    COV_WIDE: cover property (pix_valid && pix_to_outfifo);
endmodule : lpf_fetch
`default_nettype wire

// ==== testbench/lpf_mem_model.sv ====
// Frame buffer memory answering four-word burst reads
`default_nettype none
module lpf_mem_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [7:0] lat,
    output logic mem_valid,
    output logic [31:0] mem_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:511];
    logic [31:0] addr_q;
    int wait_n;
    int beat_n;
    // Read only, so words past the buffer end are never altered
    // Idle data lines flip every cycle so a stale word is never mistaken for a beat
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            beat_n <= -1;
            wait_n <= 0;
            addr_q <= 32'h0;
            mem_valid <= 1'b0;
            mem_data <= 32'h0;
        end else if (beat_n < 0) begin
            mem_valid <= 1'b0;
            mem_data <= ~mem_data;
            if (mem_req) begin
                addr_q <= mem_addr;
                wait_n <= int'(lat);
                beat_n <= 0;
            end
        end else if (wait_n > 0) begin
            mem_valid <= 1'b0;
            mem_data <= ~mem_data;
            wait_n <= wait_n - 1;
        end else begin
            mem_valid <= 1'b1;
            mem_data <= mem[addr_q[10:2] + 9'(beat_n)];
            beat_n <= (beat_n == 3) ? -1 : beat_n + 1;
        end
    end
endmodule : lpf_mem_model
`default_nettype wire

// ==== testbench/lpf_fetch_tb.sv ====
// Self-checking bench for the pixel fetch and palette front end
`include "lpf_params.svh"
`default_nettype none
module lpf_fetch_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic lcd_enable = 1'b0, frame_pulse = 1'b0, dual_panel = 1'b0, color_mode = 1'b1;
    logic active_display_select = 1'b0, byte_order_select = 1'b0;
    logic pix_ready = 1'b1, underrun_clr = 1'b0;
    logic [9:0] pixels_per_line = 10'h010;
    logic [9:0] lines_per_frame = 10'h002;
    logic [31:0] base_addr_ch1 = 32'h0, base_addr_ch2 = 32'h400;
    logic mem_req, mem_chan, mem_valid, pix_valid, pix_to_outfifo, underrun, underrun_irq;
    logic [31:0] mem_addr, mem_data, cur_addr_ch1, cur_addr_ch2;
    logic [15:0] pix_upper, pix_lower;
    logic [1:0] pixel_size_code, code;
    logic [7:0] lat = 8'h03;
    logic [16:0] up_q[$];
    logic [15:0] lo_q[$];
    logic [32:0] req_q[$];
    logic arm = 1'b0, collect = 1'b0, be = 1'b0, act = 1'b0, col = 1'b1;
    int err_count = 0, total_checks = 0, irq_n = 0, cyc = 0, ppw = 8;

    always #20 core_clk = ~core_clk;

    lpf_fetch u_dut (.core_clk, .rst, .lcd_enable, .frame_pulse, .dual_panel, .color_mode,
        .active_display_select, .byte_order_select, .pixels_per_line, .lines_per_frame,
        .base_addr_ch1, .base_addr_ch2, .mem_req, .mem_addr, .mem_chan, .mem_valid, .mem_data,
        .pix_valid, .pix_upper, .pix_lower, .pix_to_outfifo, .pix_ready, .pixel_size_code,
        .cur_addr_ch1, .cur_addr_ch2, .underrun, .underrun_irq, .underrun_clr);
    lpf_mem_model u_mem (.core_clk, .rst, .mem_req, .mem_addr, .lat, .mem_valid, .mem_data);

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic check(logic [39:0] got, logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Pre-edge values are what the design itself sampled at this edge
    always @(posedge core_clk) begin
        cyc++;
        if (underrun_irq === 1'b1) irq_n++;
        if (mem_req === 1'b1) req_q.push_back({mem_chan, mem_addr});
        if (arm && mem_valid === 1'b1) begin
            collect = 1'b1;
            arm = 1'b0;
        end
        if (collect && pix_valid === 1'b1 && pix_ready) begin
            up_q.push_back({pix_to_outfifo, pix_upper});
            lo_q.push_back(pix_lower);
        end
        if (cyc == 60000) begin
            err_count++;
            end_of_test();
        end
    end

    function automatic logic [15:0] pal(logic [7:0] idx);
        logic [31:0] w;
        w = u_mem.mem[idx[7:1]];
        w = (idx[0] ^ be) ? {16'h0, w[31:16]} : w;
        return col ? {4'h0, w[11:0]} : {12'h0, w[3:0]};
    endfunction : pal

    function automatic logic [15:0] exp_pix(int ch, int k);
        logic [31:0] w;
        int s;
        w = u_mem.mem[(ch != 0 ? 256 : (code == `LPF_PS_8) ? 128 : 8) + k / ppw];
        s = be ? ppw - 1 - k % ppw : k % ppw;
        if (ppw == 8) return pal({4'h0, w[4*s +: 4]});
        if (ppw == 4) return pal(w[8*s +: 8]);
        w = w >> (16 * s);
        return act ? w[15:0] : {4'h0, w[11:0]};
    endfunction : exp_pix

    // One frame: load memory, restart, then compare pixels and burst pattern
    task automatic frame(logic [1:0] c, logic b, logic a, logic cl, logic d, logic first);
        int n, f1, f2;
        n = 16 * int'(lines_per_frame) / (d ? 2 : 1);
        f1 = 0;
        f2 = 0;
        for (int j = 0; j < 512; j++) u_mem.mem[j] = j * 32'h9E37_79B9;
        if (!cl) for (int j = 8; j < 256; j++) u_mem.mem[j] &= 32'h3333_3333;
        if (c == `LPF_PS_WIDE) for (int j = 0; j < 8; j++) u_mem.mem[j] = 32'h0;
        u_mem.mem[0][13:12] = c;
        u_mem.mem[0][29:28] = c;
        {code, be, act, col} = {c, b, a, cl};
        ppw = (c == `LPF_PS_8) ? 4 : (c == `LPF_PS_WIDE) ? 2 : 8;
        @(posedge core_clk);
        {byte_order_select, active_display_select, color_mode, dual_panel} <= {b, a, cl, d};
        if (first) lcd_enable <= 1'b1;
        else frame_pulse <= 1'b1;
        req_q.delete();
        @(posedge core_clk);
        frame_pulse <= 1'b0;
        @(posedge core_clk);
        up_q.delete();
        lo_q.delete();
        collect = 1'b0;
        arm = 1'b1;
        for (int i = 0; i < 3000 && up_q.size() < n; i++) @(posedge core_clk);
        repeat (80) @(posedge core_clk);
        check(up_q.size() >= n, 1'b1);
        for (int k = 0; k < n && k < up_q.size(); k++) begin
            check(up_q[k], {c == `LPF_PS_WIDE && a, exp_pix(0, k)});
            if (d) check(lo_q[k], exp_pix(1, k));
        end
        foreach (req_q[i]) begin
            if (req_q[i][32] && f2++ == 0) check(req_q[i], {1'b1, base_addr_ch2});
            if (!req_q[i][32] && f1++ == 0) check(req_q[i], {1'b0, base_addr_ch1});
        end
        // Fetch may run one burst past the computed end
        n = (c == `LPF_PS_8 ? 128 : 8) + n / ppw + 3;
        check(f1 == n / 4 || f1 == n / 4 + 1, 1'b1);
        if (d) check(f2 == 1 || f2 == 2, 1'b1);
        check(cur_addr_ch1, base_addr_ch1 + 32'(n / 4 * 16));
        if (d) check(cur_addr_ch2, base_addr_ch2 + 32'((n - (c == `LPF_PS_8 ? 128 : 8)) / 4 * 16));
        if (d) check(req_q[0][32] != req_q[1][32], 1'b1);
        check(pixel_size_code, c);
    endtask : frame

    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check({mem_req, pix_valid, underrun, underrun_irq, pixel_size_code}, 6'h00);
        frame(`LPF_PS_4, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        // A frame that drains normally at its end is no underrun
        check(underrun, 1'b0);
        check(irq_n, 0);
        frame(`LPF_PS_4, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        frame(`LPF_PS_8, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        frame(`LPF_PS_8, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        frame(`LPF_PS_4, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        frame(`LPF_PS_WIDE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        frame(`LPF_PS_WIDE, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        // Slow memory starves the FIFO while the consumer keeps taking pixels
        pix_ready <= 1'b0;
        underrun_clr <= 1'b1;
        @(posedge core_clk);
        underrun_clr <= 1'b0;
        lat <= 8'h28;
        lines_per_frame <= 10'h008;
        repeat (3) @(posedge core_clk);
        check(underrun, 1'b0);
        irq_n = 0;
        pix_ready <= 1'b1;
        frame(`LPF_PS_4, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        check(underrun, 1'b1);
        check(irq_n, 1);
        end_of_test();
    end
endmodule : lpf_fetch_tb
`default_nettype wire
